// >>> pkg/usb_role_pkg.sv
package usb_role_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_LINE_STATUS = 8'h18;
	localparam logic [7:0] OFS_XCVR_ADJUST = 8'h1b;
	localparam logic [7:0] OFS_ROLE_SELECT = 8'h1f;
	localparam logic [7:0] OFS_FIFO_RD_LO  = 8'h20;
	localparam logic [7:0] OFS_FIFO_RD_HI  = 8'h21;
	localparam logic [7:0] OFS_COUNT_HI    = 8'h24;
	localparam logic [7:0] OFS_COUNT_LO    = 8'h25;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int unsigned SLEW_LSB        = 4;
	localparam int unsigned TERM_LSB        = 0;
	localparam int unsigned ROLE_BIT        = 0;
	localparam int unsigned COUNT_VALID_BIT = 7;
	localparam int unsigned COUNT_W         = 13;
	localparam int unsigned AREA_NUM        = 6;
	localparam logic [1:0]  SLEW_RST        = 2'h0;
	localparam logic [1:0]  TERM_RST        = 2'h0;
	localparam logic        ROLE_RST        = 1'b0;

	// ****************************************
	// Transceiver choices and line codes
	// ****************************************
	localparam logic [1:0] XCVR_HS   = 2'h0;
	localparam logic [1:0] XCVR_FS   = 2'h1;
	localparam logic [1:0] XCVR_RSVD = 2'h2;
	localparam logic [1:0] XCVR_LS   = 2'h3;
	localparam logic [1:0] LINE_SE0  = 2'h0;
	localparam logic [1:0] LINE_J    = 2'h1;
	localparam logic [1:0] LINE_K    = 2'h2;
	localparam logic [1:0] LINE_SE1  = 2'h3;
endpackage

// >>> hdl/pin_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	if (W < 1) begin : g_bad_w
		$error("pin_sync3: W must be at least 1");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change accepted only once two late stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (s2_q == s3_q) begin
			q <= s3_q;
		end
	end
endmodule // pin_sync3
`default_nettype wire

// >>> hdl/usb_role_regs.sv
`timescale 1ns/100ps
`default_nettype none
module usb_role_regs #(
	parameter int PTR_W = 13
) (
	input  wire logic             MCLK,
	input  wire logic             RST_N,
	input  wire logic [6:0]       CPU_WORD_ADDR,
	input  wire logic [1:0]       CPU_BE,
	input  wire logic             CPU_RD,
	input  wire logic             CPU_WR,
	input  wire logic [15:0]      CPU_WDATA,
	output var  logic [15:0]      CPU_RDATA,
	output var  logic [1:0]       CPU_RVALID,
	input  wire logic [1:0]       XCVR_SELECT,
	input  wire logic             FS_DP,
	input  wire logic             FS_DM,
	input  wire logic             LS_DP,
	input  wire logic             LS_DM,
	input  wire logic             HS_ACTIVITY,
	output var  logic [1:0]       HS_SLEW,
	output var  logic [1:0]       HS_TERM,
	output var  logic             SHARED_CLK_EN,
	output var  logic             DEV_CLK_EN,
	output var  logic             HOST_CLK_EN,
	input  wire logic [5:0]       FIFO_JOIN,
	input  wire logic [PTR_W-1:0] FIFO_WR_PTR,
	input  wire logic [7:0]       FIFO_DATA_LO,
	input  wire logic [7:0]       FIFO_DATA_HI,
	output var  logic [2:0]       FIFO_AREA,
	output var  logic [PTR_W-1:0] FIFO_RD_PTR
);
	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic       rst_meta_q;
	logic       rst_n_q;
	logic [4:0] pins_s;
	logic       fs_dp;
	logic       fs_dm;
	logic       ls_dp;
	logic       ls_dm;
	logic       act;

	if (PTR_W < 2 || PTR_W > usb_role_pkg::COUNT_W) begin : g_bad_ptr_w
		$error("usb_role_regs: PTR_W must lie in 2..13");
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	pin_sync3 #(.W(5)) u_pins (
		.clk   (MCLK),
		.rst_n (rst_n_q),
		.d     ({FS_DP, FS_DM, LS_DP, LS_DM, HS_ACTIVITY}),
		.q     (pins_s)
	);
	assign {fs_dp, fs_dm, ls_dp, ls_dm, act} = pins_s;

	// ****************************************
	// Bus line condition
	// ****************************************
	logic [1:0] line_d;
	logic [1:0] line_q;

	// Low speed has J and K swapped on the pair, hence the reversed order
	always_comb begin
		unique case (XCVR_SELECT)
			usb_role_pkg::XCVR_HS:   line_d = {1'b0, act};
			usb_role_pkg::XCVR_FS:   line_d = {fs_dm, fs_dp};
			usb_role_pkg::XCVR_LS:   line_d = {ls_dp, ls_dm};
			usb_role_pkg::XCVR_RSVD: line_d = usb_role_pkg::LINE_SE0;
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			line_q <= usb_role_pkg::LINE_SE0;
		end else begin
			line_q <= line_d;
		end
	end

	// ****************************************
	// Byte lane decode
	// ****************************************
	logic [7:0] addr0;
	logic [7:0] addr1;
	logic       adj_we;
	logic       role_we;

	assign addr0 = {CPU_WORD_ADDR, 1'b0};
	assign addr1 = {CPU_WORD_ADDR, 1'b1};

	// Every input is an argument, so continuous uses stay sensitive to it
	function automatic logic wr_hit(input logic [7:0] a, input logic wr, input logic [1:0] be,
			input logic [7:0] a0, input logic [7:0] a1);
		return wr && ((be[0] && a0 == a) || (be[1] && a1 == a));
	endfunction

	function automatic logic [7:0] wr_byte(input logic [7:0] a, input logic [15:0] w);
		return a[0] ? w[15:8] : w[7:0];
	endfunction

	assign adj_we  = wr_hit(usb_role_pkg::OFS_XCVR_ADJUST, CPU_WR, CPU_BE, addr0, addr1);
	assign role_we = wr_hit(usb_role_pkg::OFS_ROLE_SELECT, CPU_WR, CPU_BE, addr0, addr1);

	// ****************************************
	// Transceiver adjust and role select
	// ****************************************
	logic [7:0] adj_wb;
	logic [7:0] role_wb;
	logic       role_q;

	assign adj_wb  = wr_byte(usb_role_pkg::OFS_XCVR_ADJUST, CPU_WDATA);
	assign role_wb = wr_byte(usb_role_pkg::OFS_ROLE_SELECT, CPU_WDATA);

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			HS_SLEW <= usb_role_pkg::SLEW_RST;
			HS_TERM <= usb_role_pkg::TERM_RST;
		end else if (adj_we) begin
			HS_SLEW <= adj_wb[usb_role_pkg::SLEW_LSB +: 2];
			HS_TERM <= adj_wb[usb_role_pkg::TERM_LSB +: 2];
		end
	end

	// No sleep input reaches this logic, so role stays live in sleep
	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			role_q        <= usb_role_pkg::ROLE_RST;
			DEV_CLK_EN    <= ~usb_role_pkg::ROLE_RST;
			HOST_CLK_EN   <= usb_role_pkg::ROLE_RST;
			SHARED_CLK_EN <= 1'b0;
		end else begin
			SHARED_CLK_EN <= 1'b1;
			if (role_we) begin
				role_q      <= role_wb[usb_role_pkg::ROLE_BIT];
				DEV_CLK_EN  <= ~role_wb[usb_role_pkg::ROLE_BIT];
				HOST_CLK_EN <= role_wb[usb_role_pkg::ROLE_BIT];
			end
		end
	end

	// ****************************************
	// FIFO join and read pointer
	// ****************************************
	logic [2:0]       area_d;
	logic             join_any_d;
	logic             join_any_q;
	logic [PTR_W-1:0] avail;
	logic [12:0]      count;
	logic             fifo_hit;
	logic [1:0]       take;

	// Lowest joined area wins if software joins more than one
	always_comb begin
		area_d     = 3'h0;
		join_any_d = 1'b0;
		for (int n = usb_role_pkg::AREA_NUM - 1; n >= 0; n--) begin
			if (FIFO_JOIN[n]) begin
				area_d     = 3'(n);
				join_any_d = 1'b1;
			end
		end
	end

	assign avail    = join_any_q ? FIFO_WR_PTR - FIFO_RD_PTR : '0;
	assign count    = 13'(avail);
	assign fifo_hit = CPU_RD && |CPU_BE && addr0 == usb_role_pkg::OFS_FIFO_RD_LO;

	always_comb begin
		take = 2'h0;
		if (CPU_BE == 2'h3 && avail >= PTR_W'(2)) begin
			take = 2'h2;
		end else if (|CPU_BE && avail != '0) begin
			take = 2'h1;
		end
	end

	// A new join restarts the pointer for that area
	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			FIFO_AREA   <= 3'h0;
			join_any_q  <= 1'b0;
			FIFO_RD_PTR <= '0;
		end else begin
			FIFO_AREA  <= area_d;
			join_any_q <= join_any_d;
			if (area_d != FIFO_AREA || join_any_d != join_any_q) begin
				FIFO_RD_PTR <= '0;
			end else if (fifo_hit) begin
				FIFO_RD_PTR <= FIFO_RD_PTR + PTR_W'(take);
			end
		end
	end

	// ****************************************
	// Readable count pair
	// ****************************************
	logic [7:0] lo_snap_q;
	logic       hi_rd;
	logic       word_cnt;

	assign hi_rd    = CPU_RD && CPU_BE[0] && addr0 == usb_role_pkg::OFS_COUNT_HI;
	assign word_cnt = hi_rd && CPU_BE[1];

	// Low half frozen at the high read so the pair is coherent
	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lo_snap_q <= 8'h00;
		end else if (hi_rd) begin
			lo_snap_q <= count[7:0];
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	function automatic logic [7:0] reg_byte(input logic [7:0] a);
		logic [7:0] b;
		b = 8'h00;
		case (a)
			usb_role_pkg::OFS_LINE_STATUS: b[1:0] = line_q;
			usb_role_pkg::OFS_XCVR_ADJUST: begin
				b[usb_role_pkg::SLEW_LSB +: 2] = HS_SLEW;
				b[usb_role_pkg::TERM_LSB +: 2] = HS_TERM;
			end
			usb_role_pkg::OFS_ROLE_SELECT: b[usb_role_pkg::ROLE_BIT] = role_q;
			usb_role_pkg::OFS_COUNT_HI: begin
				b[4:0] = count[12:8];
				b[usb_role_pkg::COUNT_VALID_BIT] = join_any_q;
			end
			usb_role_pkg::OFS_COUNT_LO: b = lo_snap_q;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	logic [15:0] rdata_d;
	logic [1:0]  rvld_d;

	always_comb begin
		rdata_d = 16'h0000;
		rvld_d  = 2'h0;
		if (fifo_hit) begin
			rdata_d[7:0]  = CPU_BE[0] ? FIFO_DATA_LO : 8'h00;
			rdata_d[15:8] = CPU_BE[0] ? FIFO_DATA_HI : FIFO_DATA_LO;
			rvld_d[0]     = CPU_BE[0] && take != 2'h0;
			rvld_d[1]     = CPU_BE[1] && (CPU_BE[0] ? take == 2'h2 : take != 2'h0);
			if (!rvld_d[1]) begin
				rdata_d[15:8] = 8'h00;
			end
			if (!rvld_d[0]) begin
				rdata_d[7:0] = 8'h00;
			end
		end else begin
			rdata_d[7:0]  = CPU_BE[0] ? reg_byte(addr0) : 8'h00;
			rdata_d[15:8] = CPU_BE[1] ? reg_byte(addr1) : 8'h00;
			if (word_cnt) begin
				rdata_d[15:8] = count[7:0];
			end
			rvld_d = CPU_BE;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			CPU_RDATA  <= 16'h0000;
			CPU_RVALID <= 2'h0;
		end else begin
			CPU_RVALID <= CPU_RD ? rvld_d : 2'h0;
			if (CPU_RD) begin
				CPU_RDATA <= rdata_d;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!rst_n_q);

	hs_line_a: assert property (XCVR_SELECT == usb_role_pkg::XCVR_HS ##1 1'b1
		|-> line_q == {1'b0, $past(act)} && line_q[1] == 1'b0)
		else $error("hs line condition wrong");
	fs_line_a: assert property ((XCVR_SELECT == usb_role_pkg::XCVR_FS && !fs_dm && fs_dp)
		|=> line_q == usb_role_pkg::LINE_J)
		else $error("fs J not reported as 01");
	ls_line_a: assert property ((XCVR_SELECT == usb_role_pkg::XCVR_LS && ls_dm && !ls_dp)
		|=> line_q == usb_role_pkg::LINE_J)
		else $error("ls J not reported as 01");
	se_code_a: assert property ((XCVR_SELECT[0] && (XCVR_SELECT[1] ? ls_dp & ls_dm : fs_dp & fs_dm))
		|=> line_q == usb_role_pkg::LINE_SE1)
		else $error("SE1 not reported as 11");
	adj_write_a: assert property (adj_we
		|=> HS_SLEW == $past(adj_wb[5:4]) && HS_TERM == $past(adj_wb[1:0]))
		else $error("adjust fields not written");
	role_clock_a: assert property (DEV_CLK_EN == !role_q && HOST_CLK_EN == role_q)
		else $error("block clocks disagree with role");
	role_write_a: assert property (role_we
		|=> role_q == $past(role_wb[0]) ##1 SHARED_CLK_EN)
		else $error("role bit not written");
	odd_byte_a: assert property ((fifo_hit && CPU_BE == 2'h3 && avail == PTR_W'(1))
		|=> CPU_RVALID == 2'h1 && CPU_RDATA[15:8] == 8'h00)
		else $error("odd byte not single lane");
	no_join_a: assert property ((CPU_RD && !join_any_q && fifo_hit)
		|=> CPU_RVALID == 2'h0)
		else $error("read port valid without join");
	ptr_step_a: assert property ((fifo_hit && area_d == FIFO_AREA && join_any_d == join_any_q)
		|=> FIFO_RD_PTR == $past(FIFO_RD_PTR) + PTR_W'($countones(CPU_RVALID)))
		else $error("pointer step differs from bytes returned");
	pair_snap_a: assert property ((hi_rd && !CPU_BE[1])
		|=> lo_snap_q == $past(count[7:0]))
		else $error("low half not frozen at high read");

	word_read_c: cover property (fifo_hit && CPU_BE == 2'h3 ##1 CPU_RVALID == 2'h3);
	odd_read_c:  cover property (fifo_hit && CPU_BE == 2'h3 ##1 CPU_RVALID == 2'h1);
	host_role_c: cover property (role_we ##1 HOST_CLK_EN);
	ls_k_c:      cover property (XCVR_SELECT == usb_role_pkg::XCVR_LS ##1 line_q == 2'h2);
endmodule // usb_role_regs
`default_nettype wire

// >>> sim/fifo_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module fifo_mem_model #(
	parameter int PTR_W = 13
) (
	input  wire logic [PTR_W-1:0] rd_ptr,
	output var  logic [7:0]       data_lo,
	output var  logic [7:0]       data_hi
);
	// ****************************************
	// Joined area contents
	// ****************************************
	// Byte value is a fixed pattern of its place, so a pointer slip shows in the data
	logic [PTR_W-1:0] nxt;
	assign nxt = rd_ptr + 1'b1;
	assign data_lo = rd_ptr[7:0] ^ 8'ha5;
	assign data_hi = nxt[7:0] ^ 8'ha5;
endmodule // fifo_mem_model
`default_nettype wire

// >>> sim/usb_role_select_and_fifo_read_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module usb_role_select_and_fifo_read_port_tb;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [6:0]  addr = 7'h00;
	logic [1:0]  be = 2'h0;
	logic        cpu_rd = 1'b0;
	logic        cpu_wr = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [1:0]  rvalid;
	logic [1:0]  xsel = 2'h1;
	logic        fs_dp = 1'b1;
	logic        fs_dm = 1'b0;
	logic        ls_dp = 1'b0;
	logic        ls_dm = 1'b1;
	logic        hs_act = 1'b0;
	logic [1:0]  slew;
	logic [1:0]  term;
	logic        sh_en;
	logic        dev_en;
	logic        host_en;
	logic [5:0]  join_bits = 6'h00;
	logic [12:0] wr_ptr = 13'h0000;
	logic [7:0]  d_lo;
	logic [7:0]  d_hi;
	logic [2:0]  area;
	logic [12:0] rd_ptr;
	logic [15:0] got;
	logic [1:0]  gotv;
	int          failures = 0;
	int          cmp_count = 0;

	always #50 mclk = ~mclk;

	usb_role_regs #(.PTR_W(13)) uut (
		.MCLK(mclk), .RST_N(rst_n), .CPU_WORD_ADDR(addr), .CPU_BE(be),
		.CPU_RD(cpu_rd), .CPU_WR(cpu_wr), .CPU_WDATA(wdata), .CPU_RDATA(rdata),
		.CPU_RVALID(rvalid), .XCVR_SELECT(xsel), .FS_DP(fs_dp), .FS_DM(fs_dm),
		.LS_DP(ls_dp), .LS_DM(ls_dm), .HS_ACTIVITY(hs_act), .HS_SLEW(slew),
		.HS_TERM(term), .SHARED_CLK_EN(sh_en), .DEV_CLK_EN(dev_en),
		.HOST_CLK_EN(host_en), .FIFO_JOIN(join_bits), .FIFO_WR_PTR(wr_ptr),
		.FIFO_DATA_LO(d_lo), .FIFO_DATA_HI(d_hi), .FIFO_AREA(area), .FIFO_RD_PTR(rd_ptr)
	);

	fifo_mem_model #(.PTR_W(13)) fifo (.rd_ptr(rd_ptr), .data_lo(d_lo), .data_hi(d_hi));

	// ****************************************
	// Shared tasks
	// ****************************************
	function automatic logic [7:0] pat(input int p);
		pat = 8'(p) ^ 8'ha5;
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic rd(input logic [6:0] a, input logic [1:0] b);
		@(posedge mclk);
		addr <= a;
		be <= b;
		cpu_rd <= 1'b1;
		@(posedge mclk);
		cpu_rd <= 1'b0;
		#1;
		got = rdata;
		gotv = rvalid;
	endtask

	task automatic wr(input logic [6:0] a, input logic [1:0] b, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		be <= b;
		wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge mclk);
		cpu_wr <= 1'b0;
	endtask

	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_role;
		#1;
		chk({13'h0, sh_en, dev_en, host_en}, 16'h0006, "clock enables after reset");
		rd(7'h0f, 2'h2);
		chk(16'(got[15:8]), 16'h0000, "role reset");
		wr(7'h0f, 2'h2, 16'h0100);
		#1;
		chk({14'h0, dev_en, host_en}, 16'h0001, "host role clocks");
		rd(7'h0f, 2'h2);
		chk(16'(got[8]), 16'h0001, "role readback");
		wr(7'h0f, 2'h2, 16'hfe00);
		#1;
		chk({13'h0, sh_en, dev_en, host_en}, 16'h0006, "device role clocks");
		rd(7'h30, 2'h3);
		chk(got, 16'h0000, "unmapped read");
		$display("test role done");
	endtask

	task automatic test_adjust;
		for (int v = 0; v < 4; v++) begin
			wr(7'h0d, 2'h2, {2'h0, 2'(v), 2'h0, 2'(3 - v), 8'h00});
			#1;
			chk({12'h0, slew, term}, 16'(v * 4 + 3 - v), "slew and term outputs");
			rd(7'h0d, 2'h2);
			chk({12'h0, got[13:12], got[9:8]}, 16'(v * 4 + 3 - v), "adjust readback");
		end
		$display("test adjust done");
	endtask

	task automatic test_line;
		logic [1:0] sel [3];
		logic [1:0] e;
		// Reserved choice is never driven
		sel = '{usb_role_pkg::XCVR_HS, usb_role_pkg::XCVR_FS, usb_role_pkg::XCVR_LS};
		for (int m = 0; m < 3; m++) begin
			for (int p = 0; p < 4; p++) begin
				@(posedge mclk);
				xsel <= sel[m];
				fs_dp <= p[0];
				fs_dm <= p[1];
				ls_dp <= p[0];
				ls_dm <= p[1];
				hs_act <= p[0];
				repeat (8) @(posedge mclk);
				e = (m == 0) ? {1'b0, p[0]} : (m == 1) ? 2'(p) : {p[0], p[1]};
				rd(7'h0c, 2'h1);
				chk(16'(got[7:0]), 16'(e), "line condition");
			end
		end
		$display("test line done");
	endtask

	task automatic test_fifo;
		rd(7'h10, 2'h3);
		chk({14'h0, gotv}, 16'h0000, "read port without join");
		chk(got, 16'h0000, "no join data");
		@(posedge mclk);
		join_bits <= 6'h04;
		wr_ptr <= 13'd5;
		repeat (2) @(posedge mclk);
		#1;
		chk(16'(area), 16'h0002, "joined area");
		rd(7'h12, 2'h1);
		chk(16'(got[7:0]), 16'h0080, "count high");
		rd(7'h12, 2'h2);
		chk(16'(got[15:8]), 16'h0005, "count low");
		for (int i = 0; i < 2; i++) begin
			rd(7'h10, 2'h3);
			chk(16'(gotv), 16'h0003, "word valid");
			chk(got, {pat(2 * i + 1), pat(2 * i)}, "word data");
			chk(16'(rd_ptr), 16'(2 * i + 2), "pointer advance");
		end
		rd(7'h10, 2'h3);
		chk({14'h0, gotv}, 16'h0001, "odd byte valid");
		chk(got, {8'h00, pat(4)}, "odd byte data");
		chk(16'(rd_ptr), 16'h0005, "pointer odd");
		rd(7'h10, 2'h3);
		chk({14'h0, gotv}, 16'h0000, "empty read");
		chk(got, 16'h0000, "empty read data");
		chk(16'(rd_ptr), 16'h0005, "pointer held");
		rd(7'h12, 2'h3);
		chk(got, 16'h0080, "count drained");
		@(posedge mclk);
		wr_ptr <= 13'd7;
		rd(7'h10, 2'h2);
		chk({14'h0, gotv}, 16'h0002, "single lane valid");
		chk(16'(got[15:8]), 16'(pat(5)), "single lane data");
		chk(16'(rd_ptr), 16'h0006, "single lane pointer");
		$display("test fifo done");
	endtask

	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		test_role();
		test_adjust();
		test_line();
		test_fifo();
		finish_test();
	end

	initial begin
		// Whole run is under a thousand cycles; this allows five times that
		#500000;
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule // usb_role_select_and_fifo_read_port_tb
`default_nettype wire
